// ===== verilog/gpw_pkg.sv
// package: offsets, reset values and carrier types of the gpio port
package gpw_pkg;

   localparam int          PINS         = 8;
   localparam int          AW           = 12;

   localparam logic [11:0] OFS_DIR      = 12'h400;
   localparam logic [11:0] OFS_SENSE    = 12'h404;
   localparam logic [11:0] OFS_BOTH     = 12'h408;
   localparam logic [11:0] OFS_POL      = 12'h40C;
   localparam logic [11:0] OFS_MASK     = 12'h410;
   localparam logic [11:0] OFS_RAW      = 12'h414;
   localparam logic [11:0] OFS_MIS      = 12'h418;
   localparam logic [11:0] OFS_CLEAR    = 12'h41C;
   localparam logic [11:0] OFS_AFSEL    = 12'h420;
   localparam logic [11:0] OFS_DRV2     = 12'h500;
   localparam logic [11:0] OFS_DRV4     = 12'h504;
   localparam logic [11:0] OFS_DRV8     = 12'h508;
   localparam logic [11:0] OFS_ODR      = 12'h50C;
   localparam logic [11:0] OFS_PUR      = 12'h510;
   localparam logic [11:0] OFS_PDR      = 12'h514;
   localparam logic [11:0] OFS_SLEW     = 12'h518;
   localparam logic [11:0] OFS_DEN      = 12'h51C;
   localparam logic [11:0] OFS_LOCK     = 12'h520;
   localparam logic [11:0] OFS_COMMIT   = 12'h524;
   localparam logic [11:0] OFS_AMSEL    = 12'h528;
   localparam logic [11:0] OFS_PID0     = 12'hFD0;
   localparam logic [11:0] OFS_CID0     = 12'hFF0;

   localparam logic [7:0]  RST_ZERO     = 8'h00;
   localparam logic [7:0]  RST_DRV2     = 8'hFF;
   localparam logic [31:0] LOCKED_READ  = 32'h0000_0001;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] afsel;
      logic [7:0] den;
      logic [7:0] pur;
      logic [7:0] pdr;
      logic [7:0] odr;
      logic [7:0] drv2;
      logic [7:0] drv4;
      logic [7:0] drv8;
      logic [7:0] slew;
      logic [7:0] amsel;
   } gpw_pad_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ
   } gpw_bus_st_t;

endpackage : gpw_pkg

// ===== verilog/gpw_irq.sv
// per-pin interrupt detection: edge or level, polarity, both edges
`timescale 1ns/1ps
module gpw_irq
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic [7:0] level,
   input  wire logic [7:0] sense,
   input  wire logic [7:0] both,
   input  wire logic [7:0] pol,
   input  wire logic [7:0] clr,
   output logic      [7:0] raw_q
);

   logic [7:0] prev_q;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] hit;

   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (sense[i])
            hit[i] = pol[i] ? level[i] : ~level[i]; // [R23]
         else if (both[i])
            hit[i] = rise[i] | fall[i]; // [R23]
         else
            hit[i] = pol[i] ? rise[i] : fall[i]; // [R13]
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prev_q <= 8'h00;
      else if (ce)
         prev_q <= level;
   end

   // level pins follow the live condition; edge pins stay set until
   // cleared, and a new edge in the clear cycle wins over the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         raw_q <= 8'h00;
      else if (ce)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (sense[i])
               raw_q[i] <= hit[i]; // [R16]
            else
               raw_q[i] <= hit[i] | (raw_q[i] & ~clr[i]); // [R11] [R18]
         end
      end
   end

endmodule : gpw_irq

// ===== verilog/gpw_port.sv
// one gpio port: ahb-lite registers, pin drive, interrupts, commit lock
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// [R01] ordinary pins reset tri-stated: select, enable and pulls cleared
// [R02] debug pins reset with select, digital enable and pull-up set
// [R03] power-on or pin reset restores both default groups
// [R04] one parameterised port module, instantiated five times
// [R05] direction 0: pin is input, data bit captures the pin
// [R06] direction 1: pin is output, data bit drives the pin
// [R07] data register spans 256 words, address bits 9:2 mask
// [R08] masked write changes only bits whose address bit is 1
// [R09] masked read returns zero for bits whose address bit is 0
// [R10] one port interrupt output while any enabled interrupt pends
// [R11] edge interrupt stays latched until software clears it
// [R12] source holds a level interrupt steady until recognised
// [R13] sense, both-edges and polarity registers set each trigger
// [R14] mask register enables each pin onto the interrupt output
// [R15] masked status shows only pending conditions that pass mask
// [R16] raw status shows every pin meeting its condition
// [R17] unmasked trigger pin also pulses the converter trigger
// [R18] writing 1 to clear register clears pending; 0 does nothing
// [R19] software masks before changing sense, edge or polarity bits
// [R20] peripheral select gives pin to peripheral, else data register
// [R21] analog mode bit 1 bypasses the analog isolation circuit
// [R22] protected select, pull-up, enable bits need unlock and commit
// [R23] sense 0 edge, both-edges overrides polarity, polarity 1 high
// [R24] pad drive, open-drain, pulls, slew, enable held in registers
// [R25] commit register resets protected bits clear, others set
// [R26] bits of unbonded pins ignore writes and read zero
module gpw_port
#(
   parameter logic [7:0]  BONDED    = 8'hFF, // [R04]
   parameter logic [7:0]  PROTECTED = 8'h00,
   parameter logic [7:0]  DEBUG_DEF = 8'h00,
   parameter logic [7:0]  TRIG_SEL  = 8'h00,
   parameter logic [31:0] LOCK_KEY  = 32'h5A5A_A5A5,
   parameter logic [63:0] PERIPH_ID = 64'h0000_0000_0000_0011, // arbitrary
   parameter logic [31:0] CELL_ID   = 32'h0000_0022 // arbitrary
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   input  wire logic [7:0]        pin_in,
   output logic      [7:0]        pin_out,
   output logic      [7:0]        pin_oe,
   input  wire logic [7:0]        periph_out,
   input  wire logic [7:0]        periph_oe,
   output logic      [7:0]        periph_in,
   output gpw_pkg::gpw_pad_t      pad_ctrl,
   output logic                   irq,
   output logic                   converter_trigger
);

   gpw_pkg::gpw_bus_st_t st_q;
   logic [11:0]          addr_q;
   logic                 hreadyout_q;
   logic [31:0]          hrdata_q;
   logic [31:0]          rd_val;
   logic                 take;
   logic                 wr_en;
   logic [7:0]           wd;
   logic [7:0]           pin_value_register_q;
   logic [7:0]           pin_direction_q;
   logic [7:0]           irq_sense_select_q;
   logic [7:0]           irq_both_edges_q;
   logic [7:0]           irq_polarity_q;
   logic [7:0]           irq_enable_mask_q;
   logic [7:0]           irq_raw_status;
   logic [7:0]           irq_masked_status;
   logic [7:0]           irq_clear;
   logic [7:0]           protect_commit_q;
   logic                 locked_q;
   logic [7:0]           prot_ok;
   logic [7:0]           in_q;
   logic [7:0]           pin_out_q;
   logic [7:0]           pin_oe_q;
   logic [7:0]           periph_in_q;
   logic                 irq_q;
   logic                 trig_prev_q;
   logic                 trig_q;
   gpw_pkg::gpw_pad_t    pad_q;

   // replace only the bits that allow says may change
   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] allow);
      merge = (old_v & ~allow) | (new_v & allow);
   endfunction : merge

   function automatic logic [31:0] word(input logic [7:0] v);
      word = {24'h000000, v & BONDED}; // [R26]
   endfunction : word

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // bus slave: writes land in the data phase, reads take one wait
   // state so that hrdata can come straight from a flip-flop
   assign take  = hsel & htrans[1] & hready;
   assign wr_en = ce & (st_q == gpw_pkg::BUS_WRITE);
   assign wd    = hwdata[7:0] & BONDED; // [R26]

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q        <= gpw_pkg::BUS_IDLE;
         addr_q      <= 12'h000;
         hreadyout_q <= 1'b1;
         hrdata_q    <= gpw_pkg::ZERO_WORD;
      end
      else if (ce)
      begin
         case (st_q)
            gpw_pkg::BUS_IDLE,
            gpw_pkg::BUS_WRITE:
            begin
               if (take)
               begin
                  addr_q      <= haddr[11:0];
                  st_q        <= hwrite ? gpw_pkg::BUS_WRITE
                                        : gpw_pkg::BUS_READ;
                  hreadyout_q <= hwrite;
               end
               else
                  st_q <= gpw_pkg::BUS_IDLE;
            end
            gpw_pkg::BUS_READ:
            begin
               hrdata_q    <= rd_val;
               hreadyout_q <= 1'b1;
               st_q        <= gpw_pkg::BUS_IDLE;
            end
            default:
            begin
               st_q        <= gpw_pkg::BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   always_comb
   begin
      rd_val = gpw_pkg::ZERO_WORD;
      if (addr_q[11:10] == 2'b00)
         rd_val = word(pin_value_register_q & addr_q[9:2]); // [R07] [R09]
      else if (addr_q >= gpw_pkg::OFS_CID0)
         rd_val = {24'h000000, CELL_ID[8*addr_q[3:2] +: 8]};
      else if (addr_q >= gpw_pkg::OFS_PID0)
      begin
         if (addr_q[4])
            rd_val = {24'h000000, PERIPH_ID[8*addr_q[3:2] +: 8]};
         else
            rd_val = {24'h000000, PERIPH_ID[32 + 8*addr_q[3:2] +: 8]};
      end
      else
      begin
         case (addr_q)
            gpw_pkg::OFS_DIR:    rd_val = word(pin_direction_q);
            gpw_pkg::OFS_SENSE:  rd_val = word(irq_sense_select_q);
            gpw_pkg::OFS_BOTH:   rd_val = word(irq_both_edges_q);
            gpw_pkg::OFS_POL:    rd_val = word(irq_polarity_q);
            gpw_pkg::OFS_MASK:   rd_val = word(irq_enable_mask_q);
            gpw_pkg::OFS_RAW:    rd_val = word(irq_raw_status); // [R16]
            gpw_pkg::OFS_MIS:    rd_val = word(irq_masked_status); // [R15]
            gpw_pkg::OFS_AFSEL:  rd_val = word(pad_q.afsel);
            gpw_pkg::OFS_DRV2:   rd_val = word(pad_q.drv2);
            gpw_pkg::OFS_DRV4:   rd_val = word(pad_q.drv4);
            gpw_pkg::OFS_DRV8:   rd_val = word(pad_q.drv8);
            gpw_pkg::OFS_ODR:    rd_val = word(pad_q.odr);
            gpw_pkg::OFS_PUR:    rd_val = word(pad_q.pur);
            gpw_pkg::OFS_PDR:    rd_val = word(pad_q.pdr);
            gpw_pkg::OFS_SLEW:   rd_val = word(pad_q.slew);
            gpw_pkg::OFS_DEN:    rd_val = word(pad_q.den);
            gpw_pkg::OFS_AMSEL:  rd_val = word(pad_q.amsel);
            gpw_pkg::OFS_COMMIT: rd_val = word(protect_commit_q);
            gpw_pkg::OFS_LOCK:
               rd_val = locked_q ? gpw_pkg::LOCKED_READ : gpw_pkg::ZERO_WORD;
            default:             rd_val = gpw_pkg::ZERO_WORD;
         endcase
      end
   end

   // data register: output bits take masked writes, input bits follow
   // the sampled pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pin_value_register_q <= gpw_pkg::RST_ZERO;
      else if (ce)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (!pin_direction_q[i])
               pin_value_register_q[i] <= in_q[i]; // [R05]
            else if (wr_en && addr_q[11:10] == 2'b00 && addr_q[2+i])
               pin_value_register_q[i] <= wd[i]; // [R06] [R08]
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_direction_q    <= gpw_pkg::RST_ZERO;
         irq_sense_select_q <= gpw_pkg::RST_ZERO;
         irq_both_edges_q   <= gpw_pkg::RST_ZERO;
         irq_polarity_q     <= gpw_pkg::RST_ZERO;
         irq_enable_mask_q  <= gpw_pkg::RST_ZERO;
      end
      else if (wr_en)
      begin
         if (hit(addr_q, gpw_pkg::OFS_DIR))
            pin_direction_q <= merge(pin_direction_q, wd, BONDED);
         if (hit(addr_q, gpw_pkg::OFS_SENSE))
            irq_sense_select_q <= merge(irq_sense_select_q, wd, BONDED);
         if (hit(addr_q, gpw_pkg::OFS_BOTH))
            irq_both_edges_q <= merge(irq_both_edges_q, wd, BONDED);
         if (hit(addr_q, gpw_pkg::OFS_POL))
            irq_polarity_q <= merge(irq_polarity_q, wd, BONDED);
         if (hit(addr_q, gpw_pkg::OFS_MASK))
            irq_enable_mask_q <= merge(irq_enable_mask_q, wd, BONDED);
      end
   end

   // protected bits commit only while unlocked and their commit bit is 1
   assign prot_ok = BONDED & (~PROTECTED | ({8{~locked_q}} &
                                            protect_commit_q)); // [R22]

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         locked_q         <= 1'b1;
         protect_commit_q <= ~PROTECTED; // [R25]
      end
      else if (wr_en)
      begin
         if (hit(addr_q, gpw_pkg::OFS_LOCK))
            locked_q <= (hwdata != LOCK_KEY);
         // only protected bits are writable, and only while unlocked
         if (hit(addr_q, gpw_pkg::OFS_COMMIT) && !locked_q)
            protect_commit_q <= merge(protect_commit_q, wd, PROTECTED);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pad_q.afsel <= DEBUG_DEF; // [R01] [R02] [R03]
         pad_q.den   <= DEBUG_DEF; // [R01] [R02]
         pad_q.pur   <= DEBUG_DEF; // [R01] [R02]
         pad_q.pdr   <= gpw_pkg::RST_ZERO; // [R01]
         pad_q.odr   <= gpw_pkg::RST_ZERO;
         pad_q.drv2  <= gpw_pkg::RST_DRV2;
         pad_q.drv4  <= gpw_pkg::RST_ZERO;
         pad_q.drv8  <= gpw_pkg::RST_ZERO;
         pad_q.slew  <= gpw_pkg::RST_ZERO;
         pad_q.amsel <= gpw_pkg::RST_ZERO;
      end
      else if (wr_en)
      begin
         if (hit(addr_q, gpw_pkg::OFS_AFSEL))
            pad_q.afsel <= merge(pad_q.afsel, wd, prot_ok); // [R22]
         if (hit(addr_q, gpw_pkg::OFS_DEN))
            pad_q.den <= merge(pad_q.den, wd, prot_ok); // [R22]
         if (hit(addr_q, gpw_pkg::OFS_PUR))
            pad_q.pur <= merge(pad_q.pur, wd, prot_ok); // [R22]
         if (hit(addr_q, gpw_pkg::OFS_PDR))
            pad_q.pdr <= merge(pad_q.pdr, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_ODR))
            pad_q.odr <= merge(pad_q.odr, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_DRV2))
            pad_q.drv2 <= merge(pad_q.drv2, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_DRV4))
            pad_q.drv4 <= merge(pad_q.drv4, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_DRV8))
            pad_q.drv8 <= merge(pad_q.drv8, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_SLEW))
            pad_q.slew <= merge(pad_q.slew, wd, BONDED); // [R24]
         if (hit(addr_q, gpw_pkg::OFS_AMSEL))
            pad_q.amsel <= merge(pad_q.amsel, wd, BONDED); // [R21]
      end
   end

   // clear is a one-cycle strobe; raw set wins inside the detector
   assign irq_clear = (wr_en && hit(addr_q, gpw_pkg::OFS_CLEAR)) ?
                      wd : 8'h00; // [R18]
   assign irq_masked_status = irq_raw_status & irq_enable_mask_q; // [R15]

   gpw_irq u_irq
   (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .level (in_q),
      .sense (irq_sense_select_q),
      .both  (irq_both_edges_q),
      .pol   (irq_polarity_q),
      .clr   (irq_clear),
      .raw_q (irq_raw_status)
   );

   // pins are synchronous; a disabled input buffer reads as zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         in_q        <= gpw_pkg::RST_ZERO;
         periph_in_q <= gpw_pkg::RST_ZERO;
      end
      else if (ce)
      begin
         in_q        <= pin_in & pad_q.den & BONDED;
         periph_in_q <= pin_in & pad_q.den & pad_q.afsel; // [R20]
      end
   end

   // open drain only ever pulls low, so the enable follows a zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_out_q <= gpw_pkg::RST_ZERO;
         pin_oe_q  <= gpw_pkg::RST_ZERO;
      end
      else if (ce)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (pad_q.odr[i])
            begin
               pin_out_q[i] <= 1'b0;
               pin_oe_q[i]  <= BONDED[i] & ~(pad_q.afsel[i] ? periph_out[i]
                               : pin_value_register_q[i]);
            end
            else if (pad_q.afsel[i])
            begin
               pin_out_q[i] <= periph_out[i]; // [R20]
               pin_oe_q[i]  <= periph_oe[i] & BONDED[i]; // [R20]
            end
            else
            begin
               pin_out_q[i] <= pin_value_register_q[i]; // [R06]
               pin_oe_q[i]  <= pin_direction_q[i] & BONDED[i]; // [R06]
            end
         end
      end
   end

   // trigger is a single pulse when the unmasked pending TRIG_SEL pins go from none to any
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_q       <= 1'b0;
         trig_prev_q <= 1'b0;
         trig_q      <= 1'b0;
      end
      else if (ce)
      begin
         irq_q       <= |irq_masked_status; // [R10] [R14]
         trig_prev_q <= |(irq_masked_status & TRIG_SEL);
         trig_q      <= |(irq_masked_status & TRIG_SEL) &
                        ~trig_prev_q; // [R17]
      end
   end

   assign hreadyout         = hreadyout_q;
   assign hresp             = 1'b0;
   assign hrdata            = hrdata_q;
   assign pin_out           = pin_out_q;
   assign pin_oe            = pin_oe_q;
   assign periph_in         = periph_in_q;
   assign pad_ctrl          = pad_q; // [R24]
   assign irq               = irq_q;
   assign converter_trigger = trig_q;

endmodule : gpw_port

// ===== testbench/gpw_pins_model.sv
// far side model: pads with an outside driver and one peripheral
`timescale 1ns/1ps
module gpw_pins_model
#(
   parameter logic [7:0] PER_VAL = 8'hA5,
   parameter logic [7:0] PER_OE  = 8'hF0
)
(
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext,
   output logic      [7:0] pin_in,
   output logic      [7:0] periph_out,
   output logic      [7:0] periph_oe
);
   // outside source is only held by the bench between edges it chooses
   assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext);
   assign periph_out = PER_VAL;
   assign periph_oe  = PER_OE;
endmodule : gpw_pins_model

// ===== testbench/gpw_port_assertions.sv
// port checker: bus timing, reset pads, trigger and pad causes
`timescale 1ns/1ps
module gpw_port_assertions
#(
   parameter logic [7:0] DEBUG_DEF = 8'h00
)
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              ce,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [7:0]        pin_in,
   input wire logic [7:0]        periph_in,
   input wire gpw_pkg::gpw_pad_t pad_ctrl,
   input wire logic              irq,
   input wire logic              converter_trigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd;
      hsel && htrans[1] && !hwrite && hready && ce;
   endsequence
   sequence s_wr;
      hsel && htrans[1] && hwrite && hready && ce;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (s_wr |=> hreadyout)
      else $error("write inserted wait");
   a_reset_pads: assert property (disable iff (1'b0)
      rst |-> pad_ctrl.afsel == DEBUG_DEF && pad_ctrl.pur == DEBUG_DEF
      && pad_ctrl.den == DEBUG_DEF && pad_ctrl.pdr == 8'h00)
      else $error("pad defaults wrong in reset");
   a_trig_pulse: assert property (converter_trigger |=>
      !converter_trigger)
      else $error("trigger longer than one cycle");
   a_trig_irq: assert property (converter_trigger |-> irq)
      else $error("trigger without port interrupt");
   a_periph_gate: assert property (ce && $past(ce) |-> periph_in ==
      ($past(pin_in) & $past(pad_ctrl.den) & $past(pad_ctrl.afsel)))
      else $error("peripheral input not gated");
   a_pad_cause: assert property (ce && !$stable(pad_ctrl) |->
      $past(hsel && htrans[1] && hwrite && hready, 2))
      else $error("pad control changed without write");
   c_trig: cover property (converter_trigger);
endmodule : gpw_port_assertions

bind gpw_port gpw_port_assertions #(.DEBUG_DEF(DEBUG_DEF)) chk_u
(
   .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
   .periph_in(periph_in), .pad_ctrl(pad_ctrl), .irq(irq),
   .converter_trigger(converter_trigger)
);

// ===== testbench/gpw_port_test.sv
// self-checking bench of one gpio port over ahb-lite
`timescale 1ns/1ps
module gpw_port_test;
   localparam logic [31:0] KEY = 32'h1357_2468;
   logic              clk = 1'b0;
   logic              rst = 1'b0;
   logic              ce = 1'b1;
   logic              hsel = 1'b1;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'b00;
   logic              hwrite = 1'b0;
   logic [31:0]       hwdata = 32'h0;
   logic [7:0]        ext = 8'h00;
   logic              hreadyout, hresp, irq, trig;
   logic [31:0]       hrdata, rdat;
   logic [7:0]        pin_in, pin_out, pin_oe, p_out, p_oe, p_in;
   gpw_pkg::gpw_pad_t pad;
   int                err_total = 0;
   int                n_tests = 0;
   int                cyc = 0;
   int                n_trig = 0;

   gpw_port #(.PROTECTED(8'h0F), .DEBUG_DEF(8'h0F), .TRIG_SEL(8'h10),
      .LOCK_KEY(KEY), .BONDED(8'h7F)) dut_u
   (
      .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .periph_out(p_out), .periph_oe(p_oe),
      .periph_in(p_in), .pad_ctrl(pad), .irq(irq),
      .converter_trigger(trig)
   );
   gpw_pins_model pins_u
   (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in),
      .periph_out(p_out), .periph_oe(p_oe)
   );

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task test_done;
      $display("TB: tests=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   // the watchdog is the only bound on a wait for hready
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (trig === 1'b1)
         n_trig <= n_trig + 1;
      if (cyc == 6000)
      begin
         err_total++;
         test_done();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      haddr  <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus

   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd

   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   task t_reset;
      ext <= 8'h0F;
      rd(gpw_pkg::OFS_AFSEL, 32'h0F);
      rd(gpw_pkg::OFS_DEN, 32'h0F);
      rd(gpw_pkg::OFS_PUR, 32'h0F);
      rd(gpw_pkg::OFS_PDR, 32'h00);
      rd(gpw_pkg::OFS_COMMIT, 32'h70);
      rd(gpw_pkg::OFS_LOCK, 32'h01);
      chk({24'h0, p_in}, 32'h0F);
   endtask : t_reset

   task t_commit;
      wr(gpw_pkg::OFS_AFSEL, 32'h00);
      wr(gpw_pkg::OFS_COMMIT, 32'hFF);
      rd(gpw_pkg::OFS_AFSEL, 32'h0F);
      rd(gpw_pkg::OFS_COMMIT, 32'h70);
      wr(gpw_pkg::OFS_LOCK, KEY);
      rd(gpw_pkg::OFS_LOCK, 32'h00);
      wr(gpw_pkg::OFS_COMMIT, 32'hFF);
      wr(gpw_pkg::OFS_AFSEL, 32'h00);
      wr(gpw_pkg::OFS_DEN, 32'hFF);
      rd(gpw_pkg::OFS_AFSEL, 32'h00);
      rd(gpw_pkg::OFS_DEN, 32'h7F);
   endtask : t_commit

   task t_data;
      wr(gpw_pkg::OFS_DIR, 32'hFF);
      wr(12'h3FC, 32'hFF);
      wr(12'h098, 32'hEB);
      rd(12'h3FC, 32'h7B);
      rd(12'h0C4, 32'h31);
      wt(2);
      chk({24'h0, pin_out}, 32'h7B);
      chk({24'h0, pin_oe}, 32'h7F);
   endtask : t_data

   task t_input;
      ext <= 8'h5A;
      wr(gpw_pkg::OFS_DIR, 32'h00);
      wt(4);
      rd(12'h3FC, 32'h5A);
   endtask : t_input

   task t_irq;
      wr(gpw_pkg::OFS_POL, 32'hFF);
      ext <= 8'h00;
      wt(4);
      wr(gpw_pkg::OFS_CLEAR, 32'hFF);
      rd(gpw_pkg::OFS_RAW, 32'h00);
      ext <= 8'h10;
      wt(4);
      rd(gpw_pkg::OFS_RAW, 32'h10);
      rd(gpw_pkg::OFS_MIS, 32'h00);
      chk({31'h0, irq}, 32'h0);
      wr(gpw_pkg::OFS_MASK, 32'h10);
      wt(2);
      rd(gpw_pkg::OFS_MIS, 32'h10);
      chk({31'h0, irq}, 32'h1);
      chk(n_trig, 32'h1);
      wr(gpw_pkg::OFS_CLEAR, 32'h00);
      rd(gpw_pkg::OFS_RAW, 32'h10);
      wr(gpw_pkg::OFS_CLEAR, 32'h10);
      wt(2);
      rd(gpw_pkg::OFS_RAW, 32'h00);
      chk({31'h0, irq}, 32'h0);
      wr(gpw_pkg::OFS_MASK, 32'h00);
      wr(gpw_pkg::OFS_BOTH, 32'h10);
      ext <= 8'h00;
      wt(4);
      rd(gpw_pkg::OFS_RAW, 32'h10);
      wr(gpw_pkg::OFS_SENSE, 32'h10);
      wr(gpw_pkg::OFS_BOTH, 32'h00);
      wr(gpw_pkg::OFS_POL, 32'h00);
      wr(gpw_pkg::OFS_CLEAR, 32'h10);
      wt(2);
      rd(gpw_pkg::OFS_RAW, 32'h10);
      ext <= 8'h10;
      wt(4);
      rd(gpw_pkg::OFS_RAW, 32'h00);
   endtask : t_irq

   task t_pads;
      wr(gpw_pkg::OFS_DRV4, 32'h3C);
      wr(gpw_pkg::OFS_SLEW, 32'h3C);
      wr(gpw_pkg::OFS_AMSEL, 32'h3C);
      wr(12'h600, 32'hFF);
      rd(gpw_pkg::OFS_DRV4, 32'h3C);
      rd(gpw_pkg::OFS_SLEW, 32'h3C);
      rd(12'h600, 32'h00);
      chk({24'h0, pad.amsel}, 32'h3C);
      chk({24'h0, pad.drv2}, 32'hFF);
   endtask : t_pads

   // clock enable low must freeze the bus; then open drain on pin 0
   task t_freeze;
      ce <= 1'b0;
      wr(gpw_pkg::OFS_DRV8, 32'h55);
      ce <= 1'b1;
      rd(gpw_pkg::OFS_DRV8, 32'h00);
      wr(gpw_pkg::OFS_DRV8, 32'h55);
      rd(gpw_pkg::OFS_DRV8, 32'h55);
      wr(gpw_pkg::OFS_ODR, 32'h01);
      wr(gpw_pkg::OFS_DIR, 32'h01);
      wt(2);
      chk({24'h0, pin_oe}, 32'h01);
   endtask : t_freeze

   initial
   begin
      rst <= 1'b1;
      wt(16);
      rst <= 1'b0;
      wt(1);
      t_reset();
      t_commit();
      t_data();
      t_input();
      t_irq();
      t_pads();
      t_freeze();
      test_done();
   end
endmodule : gpw_port_test
